// ### arb_if.sv
`timescale 1ns/1ns
// pending requests and their levels passed to the arbiter
interface arb_if;
   logic [15:0] pend; // pending, enabled request per vector index
   logic [1:0] level [16]; // priority level per vector index
   logic [2:0] cur_level; // level of the routine in progress
   logic busy; // a routine is in progress
   logic win; // a request may be accepted
   logic [3:0] win_vec; // chosen vector index
   logic [1:0] win_level; // level of the chosen vector
   modport ctrl (output pend, level, cur_level, busy, input win, win_vec, win_level);
   modport arb (input pend, level, cur_level, busy, output win, win_vec, win_level);
endinterface

// ### core_model.sv
`timescale 1ns/1ns
// core side: takes offered vectors, returns when the bench asks
module core_model (
   input wire logic core_clk, // core clock
   input wire logic reset_n, // reset, active low
   input wire logic vector_request, // offer from the block
   input wire logic [3:0] take_wait, // cycles an offer stands first
   input wire logic ret_req, // bench asks for a return
   output logic vector_taken, // accept pulse
   output logic service_return // return pulse
);
   logic [3:0] wait_q; // cycles the offer has stood
   // accept a standing offer once, never in two cycles running
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_taken <= 1'b0;
         wait_q <= 4'h0;
         service_return <= 1'b0;
      end else begin
         service_return <= ret_req;
         if (vector_request && !vector_taken && wait_q >= take_wait) begin
            vector_taken <= 1'b1;
            wait_q <= 4'h0;
         end else begin
            vector_taken <= 1'b0;
            wait_q <= (vector_request && !vector_taken) ? wait_q + 4'h1 : 4'h0;
         end
      end
   end
endmodule

// ### irq_arbiter.sv
`timescale 1ns/1ns
// picks the highest pending level, lowest group, leftmost source
module irq_arbiter (
   arb_if.arb a // request side
);
   // group index of a vector index
   function automatic logic [2:0] group_of(input logic [3:0] v);
      unique case (v)
         4'h0, 4'h9: group_of = 3'd0;
         4'h1, 4'h8: group_of = 3'd1;
         4'h2, 4'ha: group_of = 3'd2;
         4'h3, 4'hb: group_of = 3'd3;
         4'h4, 4'hc: group_of = 3'd4;
         default: group_of = 3'd5;
      endcase
   endfunction

   // scan levels high to low, groups low to high, primary source first
   always_comb begin
      logic found;
      logic [3:0] cand;
      found = 1'b0;
      cand = 4'h0;
      a.win_vec = irq_pkg::vec_none;
      a.win_level = 2'd0;
      for (int lv = 3; lv >= 0; lv--) begin
         for (int g = 0; g < irq_pkg::num_groups; g++) begin
            for (int s = 0; s < 2; s++) begin
               // second sources of groups 0 and 1 sit at swapped indices
               cand = (s == 0) ? 4'(g) : (g == 0) ? 4'h9 : (g == 1) ? 4'h8 : 4'(g + 8);
               if (!found && a.pend[cand] && a.level[cand] == 2'(lv)
                   && group_of(cand) == 3'(g)) begin
                  found = 1'b1;
                  a.win_vec = cand;
                  a.win_level = 2'(lv);
               end
            end
         end
      end
      a.win = found && (!a.busy || {1'b0, a.win_level} > a.cur_level);
   end
endmodule

// ### irq_controller.sv
`timescale 1ns/1ns
// Functional notes
// - vector to fixed address, eight-byte steps
// - higher priority preempts running service routine
// - serial receive and transmit share vector
// - timer two overflow and reload share vector
// - spi done taken on either edge
// - global enable bit seven blocks all
// - first enable bits select six sources
// - second enable bits select seven sources
// - spi master/slave gated, slave enabled reset
// - six groups, two priority registers
// - level is high bit then low bit
// - fixed group membership of sources
// - request flag layout, resets to zero
// - hardware clears flags five to one
// - wakeup flag set even when disabled
module irq_controller (
   input wire logic core_clk, // core clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic sfr_wr, // register write strobe
   input wire logic sfr_rd, // register read strobe
   input wire logic [7:0] sfr_addr, // register address
   input wire logic [7:0] sfr_wdata, // register write data
   output logic [7:0] sfr_rdata, // registered read data
   output logic sfr_hit, // read address belongs to this block
   input wire logic pin_p03_request, // pin p0.3 request, active level high
   input wire logic pin_p04_request, // pin p0.4 request, active level high
   input wire logic timer_zero_overflow, // timer 0 request
   input wire logic timer_one_overflow, // timer 1 request
   input wire logic serial_receive_request, // serial receive request
   input wire logic serial_transmit_request, // serial transmit request
   input wire logic timer_two_overflow, // timer 2 overflow event
   input wire logic timer_two_reload_event, // timer 2 reload event
   input wire logic radio_spi_ready, // radio spi ready event
   input wire logic radio_request, // radio request line
   input wire logic spi_master_done, // master spi done line
   input wire logic spi_slave_done, // slave spi done line
   input wire logic usb_resume_request, // usb wakeup line
   input wire logic usb_request, // usb request line
   input wire logic internal_wakeup_request, // internal wakeup line
   input wire logic service_return, // core returns from a routine
   input wire logic vector_taken, // core takes the offered vector
   output logic vector_request, // a vector is offered to the core
   output logic [15:0] vector_addr, // offered vector address
   output logic [7:0] irq_request_flags // flag register view
);
   arb_if a ();

   logic [7:0] spi_source_enable_q; // spi source gating
   logic [7:0] irq_enable_first_q; // first enable register
   logic [7:0] irq_enable_second_q; // second enable register
   logic [7:0] priority_low_q; // low priority bits
   logic [7:0] priority_high_q; // high priority bits
   logic [7:0] flags_q; // request flags
   logic [7:0] flags_d; // next flags
   logic [7:0] flag_set; // hardware set terms
   logic [4:0] edge_prev_q; // previous levels of edge sources
   logic [4:0] edge_now; // current levels of edge sources
   logic [4:0] edge_seen; // edge seen per source: either edge for spi and radio, rising edge for the rest
   logic spi_line; // shared spi done line
   logic [1:0] stack_lvl_q [4]; // levels of nested routines
   logic stack_valid_q [4]; // nesting slot in use
   logic [2:0] depth_q; // nesting depth
   logic [3:0] offer_vec_q; // vector index offered to core
   logic [1:0] offer_lvl_q; // level of offered vector
   logic [7:0] rdata_d; // read mux output

   // register write decode, used by several processes
   function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] reg_addr,
                                   input logic we);
      wr_hit = we && (addr == reg_addr);
   endfunction

   // shared spi line gated per source
   assign spi_line = (spi_master_done & spi_source_enable_q[1])
                   | (spi_slave_done & spi_source_enable_q[0]);
   assign edge_now = {internal_wakeup_request, usb_request, usb_resume_request,
                      spi_line, radio_request};

   // previous levels for edge detection
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         edge_prev_q <= 5'h00;
      end else begin
         edge_prev_q <= edge_now;
      end
   end

   // either edge for spi and radio
   always_comb begin
      edge_seen[0] = edge_now[0] ^ edge_prev_q[0];
      edge_seen[1] = edge_now[1] ^ edge_prev_q[1];
      // usb lines and wakeup are rising edge
      edge_seen[2] = edge_now[2] & ~edge_prev_q[2];
      edge_seen[3] = edge_now[3] & ~edge_prev_q[3];
      edge_seen[4] = edge_now[4] & ~edge_prev_q[4];
   end

   // flag layout seven down to zero
   // timer two events are level high
   assign flag_set = {timer_two_reload_event, timer_two_overflow, edge_seen[4], edge_seen[3],
                      edge_seen[2], edge_seen[1], edge_seen[0], radio_spi_ready};

   // flag next value: software write, auto clear, then set wins
   always_comb begin
      flags_d = flags_q;
      if (wr_hit(sfr_addr, irq_pkg::addr_irq_request_flags, sfr_wr)) begin
         flags_d = sfr_wdata;
      end
      if (vector_taken && vector_request) begin
         unique case (offer_vec_q)
            irq_pkg::vec_wakeup: flags_d[irq_pkg::flag_wakeup] = 1'b0;
            irq_pkg::vec_usb: flags_d[irq_pkg::flag_usb] = 1'b0;
            irq_pkg::vec_usb_resume: flags_d[irq_pkg::flag_usb_resume] = 1'b0;
            irq_pkg::vec_spi_done: flags_d[irq_pkg::flag_spi_done] = 1'b0;
            irq_pkg::vec_radio: flags_d[irq_pkg::flag_radio] = 1'b0;
            default: flags_d = flags_d;
         endcase
      end
      flags_d = flags_d | flag_set;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= irq_pkg::rst_irq_request_flags;
      end else begin
         flags_q <= flags_d;
      end
   end

   // enable registers
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable_first_q <= irq_pkg::rst_irq_enable_first;
         irq_enable_second_q <= irq_pkg::rst_irq_enable_second;
         spi_source_enable_q <= irq_pkg::rst_spi_source_enable;
      end else begin
         if (wr_hit(sfr_addr, irq_pkg::addr_irq_enable_first, sfr_wr)) begin
            irq_enable_first_q <= sfr_wdata & irq_pkg::first_used_mask;
         end
         if (wr_hit(sfr_addr, irq_pkg::addr_irq_enable_second, sfr_wr)) begin
            irq_enable_second_q <= sfr_wdata & irq_pkg::second_used_mask;
         end
         if (wr_hit(sfr_addr, irq_pkg::addr_spi_source_enable, sfr_wr)) begin
            spi_source_enable_q <= sfr_wdata & irq_pkg::spi_used_mask;
         end
      end
   end

   // priority registers, bits five to zero
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         priority_low_q <= irq_pkg::rst_priority;
         priority_high_q <= irq_pkg::rst_priority;
      end else begin
         if (wr_hit(sfr_addr, irq_pkg::addr_priority_low_bits, sfr_wr)) begin
            priority_low_q <= sfr_wdata & irq_pkg::priority_used_mask;
         end
         if (wr_hit(sfr_addr, irq_pkg::addr_priority_high_bits, sfr_wr)) begin
            priority_high_q <= sfr_wdata & irq_pkg::priority_used_mask;
         end
      end
   end

   // pending, enabled requests per vector index
   always_comb begin
      a.pend = 16'h0000;
      a.pend[irq_pkg::vec_pin_p03] = pin_p03_request & irq_enable_first_q[0];
      a.pend[irq_pkg::vec_timer0] = timer_zero_overflow & irq_enable_first_q[1];
      a.pend[irq_pkg::vec_pin_p04] = pin_p04_request & irq_enable_first_q[2];
      a.pend[irq_pkg::vec_timer1] = timer_one_overflow & irq_enable_first_q[3];
      a.pend[irq_pkg::vec_serial] = (serial_receive_request | serial_transmit_request)
                                  & irq_enable_first_q[4];
      a.pend[irq_pkg::vec_timer2] = (flags_q[irq_pkg::flag_t2_ovf] & irq_enable_first_q[5])
                                  | (flags_q[irq_pkg::flag_reload] & irq_enable_second_q[7]);
      a.pend[irq_pkg::vec_radio_spi] = flags_q[irq_pkg::flag_radio_spi] & irq_enable_second_q[0];
      a.pend[irq_pkg::vec_radio] = flags_q[irq_pkg::flag_radio] & irq_enable_second_q[1];
      a.pend[irq_pkg::vec_spi_done] = flags_q[irq_pkg::flag_spi_done] & irq_enable_second_q[2];
      a.pend[irq_pkg::vec_usb_resume] = flags_q[irq_pkg::flag_usb_resume]
                                      & irq_enable_second_q[3];
      a.pend[irq_pkg::vec_usb] = flags_q[irq_pkg::flag_usb] & irq_enable_second_q[4];
      a.pend[irq_pkg::vec_wakeup] = flags_q[irq_pkg::flag_wakeup] & irq_enable_second_q[5];
      if (!irq_enable_first_q[irq_pkg::global_enable_bit]) begin
         a.pend = 16'h0000;
      end
   end

   // level is high bit over low bit
   generate
      for (genvar v = 0; v < 16; v++) begin : g_level
         localparam int grp = (v < 8) ? v % 8 : (v == 8) ? 1 : (v == 9) ? 0 : v - 8;
         if (grp < irq_pkg::num_groups) begin : g_used
            assign a.level[v] = {priority_high_q[grp], priority_low_q[grp]};
         end else begin : g_unused
            assign a.level[v] = 2'd0;
         end
      end
   endgenerate

   // current level, or none when idle
   assign a.busy = (depth_q != 3'd0);
   assign a.cur_level = a.busy ? {1'b0, stack_lvl_q[2'(depth_q - 3'd1)]} : 3'd0;

   // fixed tie order inside the arbiter
   irq_arbiter u_arb (
      .a(a)
   );

   // offer to the core; refreshed every cycle, dropped for one cycle when taken
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         vector_request <= 1'b0;
         offer_vec_q <= irq_pkg::vec_none;
         offer_lvl_q <= 2'd0;
         vector_addr <= irq_pkg::vector_base;
      end else if (vector_taken && vector_request) begin
         vector_request <= 1'b0;
      end else begin
         vector_request <= a.win;
         offer_vec_q <= a.win_vec;
         offer_lvl_q <= a.win_level;
         vector_addr <= irq_pkg::vector_base
                      + ({12'h000, a.win_vec} << irq_pkg::vector_step_shift);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         depth_q <= 3'd0;
         for (int i = 0; i < 4; i++) begin
            stack_lvl_q[i] <= 2'd0;
            stack_valid_q[i] <= 1'b0;
         end
      end else if (vector_taken && vector_request && depth_q < 3'd4) begin
         stack_lvl_q[2'(depth_q)] <= offer_lvl_q;
         stack_valid_q[2'(depth_q)] <= 1'b1;
         depth_q <= depth_q + 3'd1;
      end else if (service_return && depth_q != 3'd0) begin
         stack_valid_q[2'(depth_q - 3'd1)] <= 1'b0;
         depth_q <= depth_q - 3'd1;
      end
   end

   // read mux
   always_comb begin
      unique case (sfr_addr)
         irq_pkg::addr_spi_source_enable: rdata_d = spi_source_enable_q;
         irq_pkg::addr_irq_enable_first: rdata_d = irq_enable_first_q;
         irq_pkg::addr_priority_low_bits: rdata_d = priority_low_q;
         irq_pkg::addr_irq_enable_second: rdata_d = irq_enable_second_q;
         irq_pkg::addr_priority_high_bits: rdata_d = priority_high_q;
         irq_pkg::addr_irq_request_flags: rdata_d = flags_q;
         default: rdata_d = 8'h00;
      endcase
   end

   // registered read answer and flag view
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sfr_rdata <= 8'h00;
         sfr_hit <= 1'b0;
         irq_request_flags <= 8'h00;
      end else begin
         sfr_rdata <= sfr_rd ? rdata_d : 8'h00;
         sfr_hit <= sfr_rd && (rdata_d != 8'h00 || sfr_addr == irq_pkg::addr_irq_request_flags
                    || sfr_addr == irq_pkg::addr_irq_enable_first
                    || sfr_addr == irq_pkg::addr_irq_enable_second
                    || sfr_addr == irq_pkg::addr_spi_source_enable
                    || sfr_addr == irq_pkg::addr_priority_low_bits
                    || sfr_addr == irq_pkg::addr_priority_high_bits);
         irq_request_flags <= flags_q;
      end
   end
endmodule

// ### irq_controller_sva.sv
`timescale 1ns/1ns
module irq_controller_sva (
   input wire logic core_clk, // core clock
   input wire logic reset_n, // reset, active low
   input wire logic sfr_wr, // write strobe
   input wire logic [7:0] sfr_addr, // address
   input wire logic [7:0] sfr_wdata, // write data
   input wire logic timer_two_overflow, // timer 2 event
   input wire logic internal_wakeup_request, // wakeup line
   input wire logic vector_taken, // core accepts
   input wire logic vector_request, // offer
   input wire logic [15:0] vector_addr, // offered address
   input wire logic [7:0] irq_request_flags // flag view
);
   logic ge_q; // shadow of the global enable
   // follow writes of the global enable bit
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         ge_q <= 1'b0;
      end else if (sfr_wr && sfr_addr == irq_pkg::addr_irq_enable_first) begin
         ge_q <= sfr_wdata[7];
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   a_vector_in_table: assert property (vector_request |-> vector_addr[2:0] == 3'h3
      && vector_addr <= 16'h006b && vector_addr != 16'h0033 && vector_addr != 16'h003b)
      else $error("offer outside the vector table");
   a_offer_holds: assert property (
      vector_request && !vector_taken |=> vector_request)
      else $error("offer withdrawn before it was taken");
   a_taken_drops: assert property (
      vector_taken |=> !vector_request)
      else $error("offer still up after being taken");
   a_global_off: assert property (
      !ge_q && !$past(ge_q) |-> !vector_request)
      else $error("offer while globally disabled");
   a_wake_clear: assert property (
      vector_taken && vector_addr == 16'h006b |-> ##2 !irq_request_flags[5])
      else $error("wakeup flag not cleared on vectoring");
   a_ready_kept: assert property (
      vector_taken && vector_addr == 16'h0043 |-> ##2 irq_request_flags[0])
      else $error("ready flag cleared by hardware");
   a_wake_flag: assert property (
      $rose(internal_wakeup_request) |-> ##[2:3] irq_request_flags[5])
      else $error("wakeup edge not recorded");
   a_t2_flag: assert property (
      timer_two_overflow |-> ##[1:3] irq_request_flags[6])
      else $error("timer 2 overflow not recorded");
   a_flags_reset: assert property (
      $rose(reset_n) |-> irq_request_flags == 8'h00)
      else $error("flags not zero after reset");
endmodule
bind irq_controller irq_controller_sva chk_u (.core_clk, .reset_n, .sfr_wr, .sfr_addr,
   .sfr_wdata, .timer_two_overflow, .internal_wakeup_request, .vector_taken,
   .vector_request, .vector_addr, .irq_request_flags);

// ### irq_pkg.sv
package irq_pkg;
   // register addresses on the special function register port
   localparam logic [7:0] addr_spi_source_enable = 8'ha6;
   localparam logic [7:0] addr_irq_enable_first = 8'ha8;
   localparam logic [7:0] addr_priority_low_bits = 8'ha9;
   localparam logic [7:0] addr_irq_enable_second = 8'hb8;
   localparam logic [7:0] addr_priority_high_bits = 8'hb9;
   localparam logic [7:0] addr_irq_request_flags = 8'hc0;
   // reset values
   localparam logic [7:0] rst_spi_source_enable = 8'h01;
   localparam logic [7:0] rst_irq_enable_first = 8'h00;
   localparam logic [7:0] rst_priority = 8'h00;
   localparam logic [7:0] rst_irq_enable_second = 8'h00;
   localparam logic [7:0] rst_irq_request_flags = 8'h00;
   // field positions
   localparam int global_enable_bit = 7;
   localparam logic [7:0] flags_auto_clear_mask = 8'h3e;
   localparam logic [7:0] first_used_mask = 8'hbf;
   localparam logic [7:0] second_used_mask = 8'hbf;
   localparam logic [7:0] spi_used_mask = 8'h03;
   localparam logic [7:0] priority_used_mask = 8'h3f;
   // vector numbering
   localparam int num_vectors = 14;
   localparam int num_groups = 6;
   localparam logic [15:0] vector_base = 16'h0003;
   localparam int vector_step_shift = 3;
   // vector indices (address = base + index * 8)
   localparam logic [3:0] vec_pin_p03 = 4'h0;
   localparam logic [3:0] vec_timer0 = 4'h1;
   localparam logic [3:0] vec_pin_p04 = 4'h2;
   localparam logic [3:0] vec_timer1 = 4'h3;
   localparam logic [3:0] vec_serial = 4'h4;
   localparam logic [3:0] vec_timer2 = 4'h5;
   localparam logic [3:0] vec_radio_spi = 4'h8;
   localparam logic [3:0] vec_radio = 4'h9;
   localparam logic [3:0] vec_spi_done = 4'ha;
   localparam logic [3:0] vec_usb_resume = 4'hb;
   localparam logic [3:0] vec_usb = 4'hc;
   localparam logic [3:0] vec_wakeup = 4'hd;
   localparam logic [3:0] vec_none = 4'hf;
   // request flag bit positions
   localparam int flag_reload = 7;
   localparam int flag_t2_ovf = 6;
   localparam int flag_wakeup = 5;
   localparam int flag_usb = 4;
   localparam int flag_usb_resume = 3;
   localparam int flag_spi_done = 2;
   localparam int flag_radio = 1;
   localparam int flag_radio_spi = 0;
endpackage

// ### prioritized_vectored_interrupt_unit_tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module prioritized_vectored_interrupt_unit_tb_top;
   logic core_clk = 1'b0; // core clock
   logic reset_n = 1'b0; // reset, active low
   logic sfr_wr = 1'b0; // write strobe
   logic sfr_rd = 1'b0; // read strobe
   logic [7:0] sfr_addr = 8'h00; // address
   logic [7:0] sfr_wdata = 8'h00; // write data
   logic [7:0] sfr_rdata; // read data
   logic sfr_hit; // read hit
   logic hit_s; // hit of the last read
   logic [14:0] src = 15'h0000; // request lines in vec_tab order
   logic service_return, vector_taken; // from the core model
   logic vector_request; // offer
   logic [15:0] vector_addr; // offered address
   logic [7:0] irq_request_flags; // flag view
   logic ret_req = 1'b0; // ask the core to return
   logic [3:0] take_wait = 4'h0; // core answer delay
   int n_errors = 0; // mismatches
   int total_checks = 0; // comparisons
   int cyc = 0; // elapsed cycles
   // expected vector per request line
   logic [15:0] vec_tab [15] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023,
      16'h0023, 16'h002b, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h0053, 16'h005b,
      16'h0063, 16'h006b};
   // register address, reset value, writable bits
   logic [7:0] r_addr [5] = '{8'ha6, 8'ha8, 8'ha9, 8'hb8, 8'hb9};
   logic [7:0] r_rst [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] r_msk [5] = '{8'h03, 8'hbf, 8'h3f, 8'hbf, 8'h3f};
   irq_controller dut_u (.core_clk, .reset_n, .sfr_wr, .sfr_rd, .sfr_addr, .sfr_wdata,
      .sfr_rdata, .sfr_hit, .pin_p03_request(src[0]), .timer_zero_overflow(src[1]),
      .pin_p04_request(src[2]), .timer_one_overflow(src[3]),
      .serial_receive_request(src[4]), .serial_transmit_request(src[5]),
      .timer_two_overflow(src[6]), .timer_two_reload_event(src[7]),
      .radio_spi_ready(src[8]), .radio_request(src[9]), .spi_master_done(src[10]),
      .spi_slave_done(src[11]), .usb_resume_request(src[12]), .usb_request(src[13]),
      .internal_wakeup_request(src[14]), .service_return, .vector_taken,
      .vector_request, .vector_addr, .irq_request_flags);
   core_model core_u (.core_clk, .reset_n, .vector_request, .take_wait, .ret_req,
      .vector_taken, .service_return);
   // free-running clock, 4 ns period
   initial begin
      forever #2 core_clk = ~core_clk;
   end
   // verdict and end of run
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // the run needs under 1500 cycles, so 5000 means a hang
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_errors++;
         close_out();
      end
   end
   // one register write
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge core_clk);
      sfr_wr <= 1'b0;
   endtask
   // one register read, data checked one cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      #1;
      `CHK(sfr_rdata, e)
      hit_s = sfr_hit;
   endtask
   // change one request line
   task automatic setl(input int i, input logic v);
      @(posedge core_clk);
      src[i] <= v;
   endtask
   // wait for the core to take an offer, check its address
   task automatic take(input logic [15:0] e);
      int n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (vector_taken !== 1'b1 && n < 60);
      `CHK(vector_taken, 1'b1)
      `CHK(vector_addr, e)
   endtask
   // no offer for n cycles
   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge core_clk);
         `CHK(vector_request, 1'b0)
      end
   endtask
   // core leaves its innermost routine
   task automatic ret();
      @(posedge core_clk);
      ret_req <= 1'b1;
      @(posedge core_clk);
      ret_req <= 1'b0;
   endtask
   task automatic tend(input string s);
      $display("test %s done", s);
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd(r_addr[i], r_rst[i]);
         wr(r_addr[i], 8'hff);
         rd(r_addr[i], r_msk[i]);
      end
      rd(8'hc0, 8'h00);
      `CHK(hit_s, 1'b1)
      rd(8'h00, 8'h00);
      `CHK(hit_s, 1'b0)
      wr(8'ha9, 8'h00);
      wr(8'hb9, 8'h00);
      tend("registers");
      // each line alone reaches its vector; both-edge lines stay high
      for (int i = 0; i < 15; i++) begin
         // master drops first so the shared spi line can move again
         if (i == 11) setl(10, 1'b0);
         setl(i, 1'b1);
         take(vec_tab[i]);
         if (i < 9 || i > 11) src[i] <= 1'b0;
         if (i >= 6 && i <= 8) wr(8'hc0, 8'h00);
         ret();
         quiet(8);
      end
      tend("vectors");
      setl(11, 1'b0);
      take(16'h0053);
      ret();
      wr(8'ha6, 8'h00);
      setl(10, 1'b1);
      quiet(8);
      rd(8'hc0, 8'h00);
      setl(9, 1'b0);
      take(16'h004b);
      ret();
      tend("spi");
      wr(8'ha8, 8'h3f);
      setl(1, 1'b1);
      quiet(12);
      wr(8'ha8, 8'hbf);
      take(16'h000b);
      wr(8'hb9, 8'h20);
      wr(8'ha9, 8'h04);
      setl(0, 1'b1);
      quiet(10);
      setl(14, 1'b1);
      take(16'h006b);
      setl(14, 1'b0);
      setl(2, 1'b1);
      quiet(10);
      ret();
      take(16'h0013);
      setl(2, 1'b0);
      ret();
      quiet(6);
      setl(1, 1'b0);
      ret();
      take(16'h0003);
      setl(0, 1'b0);
      ret();
      tend("priority");
      wr(8'ha8, 8'h3f);
      @(posedge core_clk);
      src[0] <= 1'b1;
      src[9] <= 1'b1;
      quiet(4);
      wr(8'ha8, 8'hbf);
      take(16'h0003);
      setl(0, 1'b0);
      ret();
      take(16'h004b);
      ret();
      @(posedge core_clk);
      take_wait <= 4'h3;
      src[6] <= 1'b1;
      take(16'h002b);
      setl(6, 1'b0);
      wr(8'hc0, 8'h00);
      ret();
      wr(8'hb8, 8'h00);
      setl(14, 1'b1);
      quiet(3);
      rd(8'hc0, 8'h20);
      wr(8'hc0, 8'h00);
      rd(8'hc0, 8'h00);
      tend("flags");
      close_out();
   end
endmodule
